// ### hw/pad_defs.svh
/*
 * Constants of the arithmetic datapath: memory geometry, operand ranges,
 * decimal-coded limits and the cycle count of one execution.
 * Included by the package; the design modules use its macros without including it; holds definitions only.
 */
`ifndef PAD_DEFS_SVH
`define PAD_DEFS_SVH

`define PAD_WORD_W       16
`define PAD_DWORD_W      32
`define PAD_ADDR_W       8
`define PAD_DEPTH        256
`define PAD_RD_PORTS     3
`define PAD_RD_PORT_SRC1 0
`define PAD_RD_PORT_SRC2 1
`define PAD_RD_PORT_HOST 2

`define PAD_WORD_MOD     64'h0000_0000_0001_0000
`define PAD_DWORD_MOD    64'h0000_0001_0000_0000
`define PAD_BCD_WORD_MOD 64'h0000_0000_0000_2710
`define PAD_BCD_DWORD_MOD 64'h0000_0000_05F5_E100
`define PAD_BCD_HI_MOD   64'h0000_0000_0000_2710

`define PAD_BCD_DIGITS   8
`define PAD_DIGIT_W      4
`define PAD_DIGIT_MAX    4'h9
`define PAD_DABBLE_ADD   4'h3
`define PAD_DABBLE_MIN   4'h5

`define PAD_CMD_CYCLES   6

`endif

// ### hw/pad_pkg.sv
/*
 * Types of the arithmetic datapath: the operation code, the command that
 * travels from the rung into the sequencer, and the sequencer states.
 * Assumes pad_defs.svh is on the include path.
 */
`include "pad_defs.svh"

package pad_pkg;

    typedef enum logic [1:0]
    {
        PAD_OP_ADD = 2'h0,
        PAD_OP_SUB = 2'h1,
        PAD_OP_MUL = 2'h2,
        PAD_OP_DIV = 2'h3
    } pad_op_t;

    typedef logic [`PAD_ADDR_W-1:0] pad_addr_t;
    typedef logic [`PAD_WORD_W-1:0] pad_word_t;

    typedef struct packed
    {
        pad_op_t   op;
        logic      dword;
        logic      bcd;
        logic      with_carry;
        pad_addr_t src1;
        pad_addr_t src2;
        pad_addr_t dst;
    } pad_cmd_t;

    typedef struct packed
    {
        logic      en;
        pad_addr_t addr;
        pad_word_t data;
    } pad_wr_t;

    typedef enum logic [6:0]
    {
        PAD_ST_IDLE  = 7'h01,
        PAD_ST_RD_LO = 7'h02,
        PAD_ST_RD_HI = 7'h04,
        PAD_ST_CAP   = 7'h08,
        PAD_ST_EXEC  = 7'h10,
        PAD_ST_WR_LO = 7'h20,
        PAD_ST_WR_HI = 7'h40
    } pad_state_t;

endpackage

// ### hw/pad_word_mem.sv
/*
 * Word register file of the datapath: one write port, several read ports,
 * each read port's data held in a register (one cycle of latency).
 * Assumes a single clock; clk_en low freezes contents and read registers.
 */
`timescale 1ns/1ns

module pad_word_mem
    import pad_pkg::*;
(
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire logic                          clk_en,
    input  wire pad_wr_t                       wr,
    input  wire pad_addr_t [`PAD_RD_PORTS-1:0] rd_addr,
    output pad_word_t      [`PAD_RD_PORTS-1:0] rd_data
);

    pad_word_t mem_r [`PAD_DEPTH];

    // contents have no reset: the registers keep what software loaded
    always_ff @(posedge clock)
    begin
        if (clk_en && wr.en)
        begin
            mem_r[wr.addr] <= wr.data;
        end
    end

    genvar p;
    generate
        for (p = 0; p < `PAD_RD_PORTS; p++)
        begin : g_rd
            always_ff @(posedge clock)
            begin
                if (rst)
                begin
                    rd_data[p] <= '0;
                end
                else if (clk_en)
                begin
                    rd_data[p] <= mem_r[rd_addr[p]];
                end
            end
        end
    endgenerate

endmodule

// ### hw/pad_arith_datapath.sv
/*
 * Arithmetic execution unit: add, subtract, multiply and divide on words or
 * double words, plain binary or decimal-coded, operands and results in the
 * word register file, with carry flag, product high word and remainder.
 * Assumes rung_in and the command come from logic on the same clock.
 */
`timescale 1ns/1ns

// Behaviour
// RULE1 - addition writes the sum of both sources into the destination
// RULE2 - word forms use unsigned 16-bit sources and destination
// RULE3 - double-word forms use unsigned 32-bit sources and destination
// RULE4 - a result outside the operand range sets the carry flag
// RULE5 - the operation repeats each scan while the rung input stays true
// RULE6 - subtraction writes first source minus second source into destination
// RULE7 - multiplication writes the product of both sources into destination
// RULE8 - an oversized product puts its upper word in the product high register
// RULE9 - division divides the first source by the second source
// RULE10 - division writes quotient to destination and remainder to remainder register
// RULE11 - decimal-coded addition in word and double-word sizes
// RULE12 - decimal-coded subtraction in word and double-word sizes
// RULE13 - decimal-coded division in word and double-word sizes
// RULE14 - add-with-carry adds one more when the carry flag is set
// RULE15 - double word: low word at named address, high word at next address
// RULE16 - decimal-coded multiplication in word and double-word sizes
// RULE17 - division by zero leaves destination and remainder unchanged
module pad_arith_datapath
    import pad_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      rst,
    input  wire logic      clk_en,
    input  wire logic      rung_in,
    input  wire pad_cmd_t  cmd,
    input  wire logic      carry_clr,
    input  wire pad_wr_t   host_wr,
    input  wire pad_addr_t host_rd_addr,
    output pad_word_t      host_rd_data,
    output logic           carry_status_flag,
    output pad_word_t      product_high_word_reg,
    output logic [31:0]    remainder_reg,
    output logic           busy,
    output logic           done
);

    function automatic logic [31:0] bcd_to_bin(input logic [31:0] bcd);
        logic [31:0] acc;
        acc = '0;
        for (int i = `PAD_BCD_DIGITS - 1; i >= 0; i--)
        begin
            acc = 32'((acc * 32'h0000_000A) + 32'(bcd[i*`PAD_DIGIT_W +: `PAD_DIGIT_W]));
        end
        return acc;
    endfunction

    // shift-and-add-three; input must be below 10**8 to fit eight digits
    function automatic logic [31:0] bin_to_bcd(input logic [31:0] bin);
        logic [31:0] bcd;
        logic [31:0] val;
        bcd = '0;
        val = bin;
        for (int i = 0; i < 32; i++)
        begin
            for (int d = 0; d < `PAD_BCD_DIGITS; d++)
            begin
                if (bcd[d*`PAD_DIGIT_W +: `PAD_DIGIT_W] >= `PAD_DABBLE_MIN)
                begin
                    bcd[d*`PAD_DIGIT_W +: `PAD_DIGIT_W] =
                        bcd[d*`PAD_DIGIT_W +: `PAD_DIGIT_W] + `PAD_DABBLE_ADD;
                end
            end
            bcd = {bcd[30:0], val[31]};
            val = {val[30:0], 1'b0};
        end
        return bcd;
    endfunction

    pad_state_t  state_r;
    pad_state_t  state_nxt;
    pad_cmd_t    cmd_r;
    logic [31:0] a_r;
    logic [31:0] b_r;
    logic [31:0] res_r;
    logic [31:0] rem_res_r;
    pad_word_t   hi_res_r;
    logic        ovf_r;
    logic        prod_big_r;
    logic        div_zero_r;

    pad_wr_t                       mem_wr;
    pad_addr_t [`PAD_RD_PORTS-1:0] mem_rd_addr;
    pad_word_t [`PAD_RD_PORTS-1:0] mem_rd_data;

    // sequencer: a new run starts from idle each time the rung is still true
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            PAD_ST_IDLE:  state_nxt = rung_in ? PAD_ST_RD_LO : PAD_ST_IDLE;  // [RULE5]
            PAD_ST_RD_LO: state_nxt = PAD_ST_RD_HI;
            PAD_ST_RD_HI: state_nxt = PAD_ST_CAP;
            PAD_ST_CAP:   state_nxt = PAD_ST_EXEC;
            PAD_ST_EXEC:  state_nxt = PAD_ST_WR_LO;
            PAD_ST_WR_LO: state_nxt = cmd_r.dword ? PAD_ST_WR_HI : PAD_ST_IDLE;
            PAD_ST_WR_HI: state_nxt = PAD_ST_IDLE;
            default:      state_nxt = PAD_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_r <= PAD_ST_IDLE;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cmd_r <= '0;
        end
        else if (clk_en && state_r == PAD_ST_IDLE && rung_in)
        begin
            cmd_r <= cmd;
        end
    end

    // high words sit one address above the named low word
    always_comb
    begin
        mem_rd_addr[`PAD_RD_PORT_SRC1] = cmd_r.src1;
        mem_rd_addr[`PAD_RD_PORT_SRC2] = cmd_r.src2;
        mem_rd_addr[`PAD_RD_PORT_HOST] = host_rd_addr;
        if (state_r == PAD_ST_RD_HI)
        begin
            mem_rd_addr[`PAD_RD_PORT_SRC1] = pad_addr_t'(cmd_r.src1 + 1'b1);  // [RULE15]
            mem_rd_addr[`PAD_RD_PORT_SRC2] = pad_addr_t'(cmd_r.src2 + 1'b1);  // [RULE15]
        end
    end

    // word forms keep the upper half of each operand at zero
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            a_r <= '0;
            b_r <= '0;
        end
        else if (clk_en)
        begin
            if (state_r == PAD_ST_RD_HI)
            begin
                a_r <= {16'h0000, mem_rd_data[`PAD_RD_PORT_SRC1]};  // [RULE2]
                b_r <= {16'h0000, mem_rd_data[`PAD_RD_PORT_SRC2]};  // [RULE2]
            end
            else if (state_r == PAD_ST_CAP && cmd_r.dword)
            begin
                a_r[31:16] <= mem_rd_data[`PAD_RD_PORT_SRC1];  // [RULE3] [RULE15]
                b_r[31:16] <= mem_rd_data[`PAD_RD_PORT_SRC2];  // [RULE3] [RULE15]
            end
        end
    end

    // all forms work on binary values; decimal-coded ones convert at both ends
    logic [63:0] a_bin;
    logic [63:0] b_bin;
    logic [63:0] modulus;
    logic [63:0] full;
    logic [63:0] wrapped;
    logic [63:0] hi_bin;
    logic [31:0] res_nxt;
    logic [31:0] rem_nxt;
    pad_word_t   hi_nxt;
    logic        ovf_nxt;

    always_comb
    begin
        a_bin   = cmd_r.bcd ? 64'(bcd_to_bin(a_r)) : 64'(a_r);  // [RULE11] [RULE12]
        b_bin   = cmd_r.bcd ? 64'(bcd_to_bin(b_r)) : 64'(b_r);  // [RULE13] [RULE16]
        modulus = cmd_r.bcd
                ? (cmd_r.dword ? `PAD_BCD_DWORD_MOD : `PAD_BCD_WORD_MOD)
                : (cmd_r.dword ? `PAD_DWORD_MOD : `PAD_WORD_MOD);  // [RULE2] [RULE3]
        full    = '0;
        wrapped = '0;
        hi_bin  = '0;
        rem_nxt = '0;
        ovf_nxt = 1'b0;
        case (cmd_r.op)
            PAD_OP_ADD:
            begin
                full    = a_bin + b_bin  // [RULE1]
                        + 64'(cmd_r.with_carry & carry_status_flag);  // [RULE14]
                ovf_nxt = full >= modulus;  // [RULE4]
                wrapped = ovf_nxt ? full - modulus : full;
            end
            PAD_OP_SUB:
            begin
                ovf_nxt = a_bin < b_bin;  // [RULE4]
                wrapped = ovf_nxt ? a_bin + modulus - b_bin : a_bin - b_bin;  // [RULE6]
            end
            PAD_OP_MUL:
            begin
                full    = a_bin * b_bin;  // [RULE7]
                ovf_nxt = full >= modulus;  // [RULE4]
                wrapped = full % modulus;
                hi_bin  = full / modulus;  // [RULE8]
            end
            PAD_OP_DIV:
            begin
                if (b_bin != 64'h0)
                begin
                    wrapped = a_bin / b_bin;  // [RULE9]
                    rem_nxt = 32'(a_bin % b_bin);
                end
            end
            default: wrapped = '0;
        endcase
        res_nxt = cmd_r.bcd ? bin_to_bcd(wrapped[31:0]) : wrapped[31:0];
        hi_nxt  = hi_bin[15:0];
        if (cmd_r.bcd)
        begin
            rem_nxt = bin_to_bcd(rem_nxt);
            hi_nxt  = pad_word_t'(bin_to_bcd(32'(hi_bin % `PAD_BCD_HI_MOD)));
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            res_r      <= '0;
            rem_res_r  <= '0;
            hi_res_r   <= '0;
            ovf_r      <= 1'b0;
            prod_big_r <= 1'b0;
            div_zero_r <= 1'b0;
        end
        else if (clk_en && state_r == PAD_ST_EXEC)
        begin
            res_r      <= res_nxt;
            rem_res_r  <= rem_nxt;
            hi_res_r   <= hi_nxt;
            ovf_r      <= ovf_nxt;
            prod_big_r <= (cmd_r.op == PAD_OP_MUL) && ovf_nxt;
            div_zero_r <= (cmd_r.op == PAD_OP_DIV) && (b_bin == 64'h0);
        end
    end

    // datapath writes take the port; a host write in those cycles is dropped
    always_comb
    begin
        mem_wr = host_wr;
        if (state_r == PAD_ST_WR_LO)
        begin
            mem_wr.en   = !div_zero_r;  // [RULE17]
            mem_wr.addr = cmd_r.dst;  // [RULE10]
            mem_wr.data = res_r[15:0];
        end
        else if (state_r == PAD_ST_WR_HI)
        begin
            mem_wr.en   = !div_zero_r;  // [RULE17]
            mem_wr.addr = pad_addr_t'(cmd_r.dst + 1'b1);  // [RULE15]
            mem_wr.data = res_r[31:16];
        end
    end

    pad_word_mem u_mem
    (
        .clock   (clock),
        .rst     (rst),
        .clk_en  (clk_en),
        .wr      (mem_wr),
        .rd_addr (mem_rd_addr),
        .rd_data (mem_rd_data)
    );

    assign host_rd_data = mem_rd_data[`PAD_RD_PORT_HOST];

    // an overflow in the same cycle as a clear keeps the flag set
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            carry_status_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            if (state_r == PAD_ST_WR_LO && ovf_r)
            begin
                carry_status_flag <= 1'b1;  // [RULE4]
            end
            else if (carry_clr)
            begin
                carry_status_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            product_high_word_reg <= '0;
            remainder_reg         <= '0;
        end
        else if (clk_en && state_r == PAD_ST_WR_LO)
        begin
            if (prod_big_r)
            begin
                product_high_word_reg <= hi_res_r;  // [RULE8]
            end
            if (cmd_r.op == PAD_OP_DIV && !div_zero_r)
            begin
                remainder_reg <= rem_res_r;  // [RULE10] [RULE17]
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (clk_en)
        begin
            busy <= state_nxt != PAD_ST_IDLE;
            done <= state_nxt == PAD_ST_IDLE && state_r != PAD_ST_IDLE;
        end
    end

endmodule

// ### tb/pad_arith_checker.sv
/*
 * Checker of run timing, pulse shape and flag causes of the datapath.
 * Assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/1ns

module pad_arith_checker
    import pad_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        clk_en,
    input wire logic        rung_in,
    input wire pad_cmd_t    cmd,
    input wire logic        carry_clr,
    input wire logic        carry_status_flag,
    input wire logic [31:0] remainder_reg,
    input wire logic        busy,
    input wire logic        done
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // a stalled run is longer, so the fixed counts need clk_en high throughout
    sequence s_word_run;
        (!busy && rung_in && clk_en && !cmd.dword) ##1 clk_en [*5];
    endsequence
    sequence s_dword_run;
        (!busy && rung_in && clk_en && cmd.dword) ##1 clk_en [*6];
    endsequence

    a_word_run_len: assert property (s_word_run |=> done && !busy)
        else $error("word run length wrong");
    a_dword_run_len: assert property (s_dword_run |=> done && !busy)
        else $error("double word run length wrong");
    a_run_start_busy: assert property (!busy && rung_in && clk_en |=> busy [*5])
        else $error("run did not start or hold busy");
    a_done_one_cycle: assert property (done && clk_en |=> !done)
        else $error("done longer than one cycle");
    a_done_from_run: assert property ($rose(done) |-> $past(busy))
        else $error("done without a run");
    a_carry_clear_cause: assert property ($fell(carry_status_flag) |-> $past(carry_clr))
        else $error("carry dropped without clear");
    a_carry_set_cause: assert property ($rose(carry_status_flag) |-> $past(busy))
        else $error("carry set outside a run");
    a_rem_from_run: assert property ($changed(remainder_reg) |-> $past(busy))
        else $error("remainder changed outside a run");
    a_freeze_holds: assert property (!clk_en |=> $stable(done) && $stable(busy))
        else $error("outputs moved while clock enable low");
endmodule

bind pad_arith_datapath pad_arith_checker u_chk
(
    .clock(clock), .rst(rst), .clk_en(clk_en), .rung_in(rung_in), .cmd(cmd),
    .carry_clr(carry_clr), .carry_status_flag(carry_status_flag),
    .remainder_reg(remainder_reg), .busy(busy), .done(done)
);

// ### tb/tb.sv
/*
 * Testbench of the arithmetic datapath: loads operands through the host
 * port, runs each operation and compares with hand-worked results.
 * Assumes the checker file is compiled with it and binds itself.
 */
`timescale 1ns/1ns

module tb
    import pad_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        rung_in = 1'b0;
    pad_cmd_t    cmd = '0;
    logic        carry_clr = 1'b0;
    pad_wr_t     host_wr = '0;
    pad_addr_t   host_rd_addr = '0;
    pad_word_t   host_rd_data;
    logic        carry_status_flag;
    pad_word_t   product_high_word_reg;
    logic [31:0] remainder_reg;
    logic        busy;
    logic        done;
    logic        fz = 1'b0;
    int          n_fail = 0;
    int          checks = 0;
    int          cyc = 0;

    pad_arith_datapath u_dut
    (
        .clock(clock), .rst(rst), .clk_en(clk_en), .rung_in(rung_in), .cmd(cmd),
        .carry_clr(carry_clr), .host_wr(host_wr), .host_rd_addr(host_rd_addr),
        .host_rd_data(host_rd_data), .carry_status_flag(carry_status_flag),
        .product_high_word_reg(product_high_word_reg), .remainder_reg(remainder_reg),
        .busy(busy), .done(done)
    );

    always #25 clock = ~clock;

    task automatic results();
        if (n_fail == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // the cycle ceiling is about ten times the expected length of the whole test
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_fail++;
            results();
        end
    end

    task automatic chk32(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic chk1(string nm, logic e, logic g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask

    task automatic tick();
        @(posedge clock);
        #1;
    endtask

    task automatic wr(pad_addr_t a, pad_word_t d);
        tick();
        host_wr = '{1'b1, a, d};
        tick();
        host_wr.en = 1'b0;
    endtask

    task automatic ld(pad_addr_t a, logic [31:0] v, logic dw);
        wr(a, v[15:0]);
        if (dw)
            wr(a + 8'h01, v[31:16]);
    endtask

    task automatic rd(pad_addr_t a, logic dw, output logic [31:0] v);
        tick();
        host_rd_addr = a;
        tick();
        v = {16'h0000, host_rd_data};
        if (dw)
        begin
            host_rd_addr = a + 8'h01;
            tick();
            v[31:16] = host_rd_data;
        end
    endtask

    task automatic clr();
        tick();
        carry_clr = 1'b1;
        tick();
        carry_clr = 1'b0;
    endtask

    // cmd is scrambled once taken, as a busy run must ignore it
    task automatic run(pad_cmd_t c);
        int n;
        tick();
        cmd = c;
        rung_in = 1'b1;
        tick();
        rung_in = 1'b0;
        cmd.op = pad_op_t'(~c.op);
        if (fz)
        begin
            clk_en = 1'b0;
            repeat (3) tick();
            clk_en = 1'b1;
        end
        n = 0;
        while (done !== 1'b1 && n < 20)
        begin
            tick();
            n++;
        end
        chk1("done", 1'b1, done);
    endtask

    // f holds dword, decimal coding and with-carry, in that order
    task automatic calc(pad_op_t o, logic [2:0] f, logic [31:0] a, logic [31:0] b,
                        logic [31:0] e);
        logic [31:0] v;
        ld(8'h10, a, f[2]);
        ld(8'h20, b, f[2]);
        run('{o, f[2], f[1], f[0], 8'h10, 8'h20, 8'h30});
        rd(8'h30, f[2], v);
        chk32("dst", e, v);
    endtask

    task automatic t_word();
        clr();
        calc(PAD_OP_ADD, 3'b000, 32'hFFFF, 32'h0002, 32'h0001);
        chk1("carry", 1'b1, carry_status_flag);
        clr();
        chk1("carry", 1'b0, carry_status_flag);
        calc(PAD_OP_SUB, 3'b000, 32'h0010, 32'h0007, 32'h0009);
        chk1("carry", 1'b0, carry_status_flag);
        calc(PAD_OP_SUB, 3'b000, 32'h0002, 32'h0005, 32'hFFFD);
        chk1("carry", 1'b1, carry_status_flag);
        calc(PAD_OP_MUL, 3'b000, 32'h0300, 32'h0100, 32'h0000);
        chk32("high", 32'h0003, {16'h0000, product_high_word_reg});
        calc(PAD_OP_DIV, 3'b000, 32'h0018, 32'h0005, 32'h0004);
        chk32("rem", 32'h0004, remainder_reg);
        calc(PAD_OP_DIV, 3'b000, 32'h0019, 32'h0000, 32'h0004);
        chk32("rem", 32'h0004, remainder_reg);
    endtask

    task automatic t_dword();
        clr();
        calc(PAD_OP_ADD, 3'b100, 32'h0001FFFF, 32'h00020001, 32'h00040000);
        chk1("carry", 1'b0, carry_status_flag);
        calc(PAD_OP_ADD, 3'b100, 32'hFFFFFFFF, 32'h00000002, 32'h00000001);
        chk1("carry", 1'b1, carry_status_flag);
        calc(PAD_OP_SUB, 3'b100, 32'h00010000, 32'h00000001, 32'h0000FFFF);
        calc(PAD_OP_MUL, 3'b100, 32'h00010000, 32'h00030000, 32'h00000000);
        chk32("high", 32'h0003, {16'h0000, product_high_word_reg});
        calc(PAD_OP_DIV, 3'b100, 32'h00030001, 32'h00000002, 32'h00018000);
        chk32("rem", 32'h00000001, remainder_reg);
    endtask

    task automatic t_bcd();
        calc(PAD_OP_ADD, 3'b010, 32'h9999, 32'h0002, 32'h0001);
        calc(PAD_OP_SUB, 3'b010, 32'h0022, 32'h0013, 32'h0009);
        calc(PAD_OP_MUL, 3'b010, 32'h0003, 32'h0007, 32'h0021);
        calc(PAD_OP_MUL, 3'b010, 32'h5000, 32'h0003, 32'h5000);
        chk32("high", 32'h0001, {16'h0000, product_high_word_reg});
        calc(PAD_OP_DIV, 3'b010, 32'h0014, 32'h0003, 32'h0004);
        chk32("rem", 32'h0002, remainder_reg);
        calc(PAD_OP_ADD, 3'b110, 32'h00999999, 32'h00000001, 32'h01000000);
        calc(PAD_OP_SUB, 3'b110, 32'h01000000, 32'h00000001, 32'h00999999);
        calc(PAD_OP_MUL, 3'b110, 32'h00010000, 32'h00000012, 32'h00120000);
        calc(PAD_OP_DIV, 3'b110, 32'h00100000, 32'h00000003, 32'h00033333);
        chk32("rem", 32'h00000001, remainder_reg);
    endtask

    task automatic t_carry_in();
        calc(PAD_OP_ADD, 3'b000, 32'hFFFF, 32'h0001, 32'h0000);
        calc(PAD_OP_ADD, 3'b001, 32'h0011, 32'h0019, 32'h002B);
        clr();
        calc(PAD_OP_ADD, 3'b001, 32'h0011, 32'h0019, 32'h002A);
    endtask

    // the rung stays high, so each run re-reads the previous result
    task automatic t_repeat();
        logic [31:0] v;
        int          k;
        int          n;
        ld(8'h40, 32'h0005, 1'b0);
        ld(8'h41, 32'h0001, 1'b0);
        tick();
        cmd = '{PAD_OP_ADD, 1'b0, 1'b0, 1'b0, 8'h40, 8'h41, 8'h40};
        rung_in = 1'b1;
        k = 0;
        n = 0;
        while (k < 3 && n < 60)
        begin
            tick();
            n++;
            if (done === 1'b1)
                k++;
        end
        rung_in = 1'b0;
        rd(8'h40, 1'b0, v);
        chk32("repeat", 32'h0008, v);
    endtask

    task automatic t_freeze();
        fz = 1'b1;
        calc(PAD_OP_ADD, 3'b000, 32'h1234, 32'h1111, 32'h2345);
        fz = 1'b0;
    endtask

    initial
    begin
        repeat (10) @(posedge clock);
        #1;
        rst = 1'b0;
        t_word();
        t_dword();
        t_bcd();
        t_carry_in();
        t_repeat();
        t_freeze();
        results();
    end
endmodule
